// file: src/ulc_consts.vh
// Constants for the upstream link control register
`ifndef ULC_CONSTS_VH
`define ULC_CONSTS_VH
`define ULC_LINK_CONTROL_OFFSET 8'ha0
`define ULC_LINK_CONTROL_RESET 16'h0000
`define ULC_WRITABLE_MASK 16'h01c3
`define ULC_BIT_CLKREQ_EN 8
`define ULC_BIT_EXT_SYNC 7
`define ULC_BIT_COMMON_CLK 6
`define ULC_BIT_RETRAIN 5
`define ULC_BIT_LINK_OFF 4
`define ULC_BIT_RCB 3
`define ULC_ASPM_HI 1
`define ULC_ASPM_LO 0
`define ULC_ASPM_OFF 2'h0
`define ULC_ASPM_L0S 2'h1
`define ULC_ASPM_RSVD 2'h2
`define ULC_ASPM_BOTH 2'h3
`define ULC_FTS_NORMAL 8'h20
`define ULC_FTS_EXTENDED 8'hff
`define ULC_L1_LAT_ADD 3'h2
`define ULC_CC_LAT_SUB 3'h1
`endif

// file: src/ulc_latency_adjust.v
// Exit latency adjustment from clock request and common clock settings
`timescale 1ns/100ps
`include "ulc_consts.vh"
module ulc_latency_adjust (
  input wire ref_clk,
  input wire reset,
  input wire clkreq_en,
  input wire common_clk,
  input wire [2:0] l1_base,
  input wire [2:0] l0s_base,
  output reg [2:0] l1_exit_latency_field,
  output reg [2:0] l0s_exit_latency
);
  reg [3:0] l1_sum;
  reg [2:0] l1_cc;
  reg [2:0] l0s_cc;

  always @* begin
    // A common reference clock shortens both exit times by one code; code zero stays at zero
    l1_cc = (common_clk && l1_base != 3'h0) ? l1_base - `ULC_CC_LAT_SUB : l1_base;
    l0s_cc = (common_clk && l0s_base != 3'h0) ? l0s_base - `ULC_CC_LAT_SUB : l0s_base;
    // PLL relock under clock request lengthens L1 exit; saturate at the top code
    l1_sum = clkreq_en ? {1'b0, l1_cc} + {1'b0, `ULC_L1_LAT_ADD} : {1'b0, l1_cc};
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      l1_exit_latency_field <= 3'h0;
      l0s_exit_latency <= 3'h0;
    end else begin
      l1_exit_latency_field <= l1_sum[3] ? 3'h7 : l1_sum[2:0];
      l0s_exit_latency <= l0s_cc;
    end
  end
endmodule // ulc_latency_adjust

// file: src/ulc_link_control.v
// Upstream port link control register with its power management decode
`timescale 1ns/100ps
`include "ulc_consts.vh"
// Contract
// - Reserved bits read zero, ignore writes
// - Bit 8 enables clock request mechanism
// - Clock request raises reported L1 exit latency
// - Bit 7 extends FTS and adds TS2
// - Bit 6 marks common clock, adjusts latencies
// - Retrain bit reads zero, no effect
// - Link disable bit reads zero, no effect
// - Completion boundary hardwired zero, 64 bytes
// - ASPM field decode; 10 reserved
module ulc_link_control (
  input wire ref_clk,
  input wire reset,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [1:0] cfg_be,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata,
  input wire [2:0] l1_base_latency,
  input wire [2:0] l0s_base_latency,
  output reg clock_request_pm_enable,
  output reg extended_sync,
  output reg common_refclk_config,
  output reg [1:0] active_state_pm_control,
  output reg l0s_entry_allowed,
  output reg l1_entry_allowed,
  output reg aspm_reserved_seen,
  output reg [7:0] l1_exit_fts_count,
  output reg l1_exit_extra_ts2,
  output wire [2:0] l1_exit_latency_field,
  output wire [2:0] l0s_exit_latency
);
  // ****************************************
  // Register storage
  // ****************************************
  reg [15:0] link_control_q;
  reg [15:0] link_control_d;
  wire hit;
  wire wr_hit;
  wire rd_hit;
  wire [15:0] lane_mask;
  wire [15:0] write_mask;

  assign hit = (cfg_addr == `ULC_LINK_CONTROL_OFFSET);
  assign wr_hit = cfg_wr & hit;
  assign rd_hit = cfg_rd & hit;
  assign lane_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  // Only bits 8:6 and 1:0 can ever take a written one
  assign write_mask = lane_mask & `ULC_WRITABLE_MASK;

  always @* begin
    link_control_d = link_control_q;
    if (wr_hit) begin
      link_control_d = (link_control_q & ~write_mask) | (cfg_wdata & write_mask);
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      link_control_q <= `ULC_LINK_CONTROL_RESET;
    end else begin
      link_control_q <= link_control_d;
    end
  end

  // ****************************************
  // Stored fields
  // ****************************************
  wire stored_clkreq;
  wire stored_ext_sync;
  wire stored_common_clk;
  wire [1:0] stored_aspm;

  assign stored_clkreq = link_control_q[`ULC_BIT_CLKREQ_EN];
  assign stored_ext_sync = link_control_q[`ULC_BIT_EXT_SYNC];
  assign stored_common_clk = link_control_q[`ULC_BIT_COMMON_CLK];
  assign stored_aspm = link_control_q[`ULC_ASPM_HI:`ULC_ASPM_LO];

  // ****************************************
  // Read path
  // ****************************************
  wire [15:0] read_word;

  // Fixed bits are built as constants, so no stray store can leak out on a read
  assign read_word = {
    7'h00,
    stored_clkreq,
    stored_ext_sync,
    stored_common_clk,
    1'b0,
    1'b0,
    1'b0,
    1'b0,
    stored_aspm
  };

  always @(posedge ref_clk) begin
    if (reset) begin
      cfg_rdata <= `ULC_LINK_CONTROL_RESET;
    end else if (cfg_rd) begin
      // Unmapped reads return zero rather than holding stale data
      cfg_rdata <= rd_hit ? read_word : 16'h0000;
    end
  end

  // ****************************************
  // Power management decode
  // ****************************************
  reg l0s_allow_d;
  reg l1_allow_d;
  reg aspm_rsvd_d;
  reg [7:0] fts_count_d;
  reg extra_ts2_d;

  always @* begin
    l0s_allow_d = 1'b0;
    l1_allow_d = 1'b0;
    aspm_rsvd_d = 1'b0;
    // Reserved code enables nothing rather than guessing intent
    case (stored_aspm)
      `ULC_ASPM_OFF: begin
        l0s_allow_d = 1'b0;
        l1_allow_d = 1'b0;
        aspm_rsvd_d = 1'b0;
      end
      `ULC_ASPM_L0S: begin
        l0s_allow_d = 1'b1;
        l1_allow_d = 1'b0;
        aspm_rsvd_d = 1'b0;
      end
      `ULC_ASPM_RSVD: begin
        l0s_allow_d = 1'b0;
        l1_allow_d = 1'b0;
        aspm_rsvd_d = 1'b1;
      end
      `ULC_ASPM_BOTH: begin
        l0s_allow_d = 1'b1;
        l1_allow_d = 1'b1;
        aspm_rsvd_d = 1'b0;
      end
      default: begin
        l0s_allow_d = 1'b0;
        l1_allow_d = 1'b0;
        aspm_rsvd_d = 1'b0;
      end
    endcase
  end

  always @* begin
    fts_count_d = `ULC_FTS_NORMAL;
    extra_ts2_d = 1'b0;
    // A longer run gives the far receiver more time to regain lock after L1
    case (stored_ext_sync)
      1'b1: begin
        fts_count_d = `ULC_FTS_EXTENDED;
        extra_ts2_d = 1'b1;
      end
      default: begin
        fts_count_d = `ULC_FTS_NORMAL;
        extra_ts2_d = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Registered controls
  // ****************************************
  always @(posedge ref_clk) begin
    if (reset) begin
      clock_request_pm_enable <= 1'b0;
      extended_sync <= 1'b0;
      common_refclk_config <= 1'b0;
    end else begin
      clock_request_pm_enable <= stored_clkreq;
      extended_sync <= stored_ext_sync;
      common_refclk_config <= stored_common_clk;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      l1_exit_fts_count <= `ULC_FTS_NORMAL;
      l1_exit_extra_ts2 <= 1'b0;
    end else begin
      l1_exit_fts_count <= fts_count_d;
      l1_exit_extra_ts2 <= extra_ts2_d;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      active_state_pm_control <= `ULC_ASPM_OFF;
      l0s_entry_allowed <= 1'b0;
      l1_entry_allowed <= 1'b0;
      aspm_reserved_seen <= 1'b0;
    end else begin
      active_state_pm_control <= stored_aspm;
      l0s_entry_allowed <= l0s_allow_d;
      l1_entry_allowed <= l1_allow_d;
      aspm_reserved_seen <= aspm_rsvd_d;
    end
  end

  // ****************************************
  // Exit latency reporting
  // ****************************************
  // Latency codes come out one edge after the stored bits, in step with the controls
  ulc_latency_adjust u_lat (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkreq_en(stored_clkreq),
    .common_clk(stored_common_clk),
    .l1_base(l1_base_latency),
    .l0s_base(l0s_base_latency),
    .l1_exit_latency_field(l1_exit_latency_field),
    .l0s_exit_latency(l0s_exit_latency)
  );
endmodule // ulc_link_control

// file: tb/tb.sv
// Random and corner tests of the link control register
`timescale 1ns/100ps
`include "ulc_consts.vh"
module tb;
  reg ref_clk = 1'h0, reset = 1'h1, cfg_wr = 1'h0, cfg_rd = 1'h0;
  reg [7:0] cfg_addr = 8'h0, a;
  reg [1:0] cfg_be = 2'h0, b;
  reg [15:0] cfg_wdata = 16'h0, exp_q = 16'h0, r = 16'h61, m, d;
  reg [5:0] pick = 6'h0;
  wire [15:0] cfg_rdata;
  wire [7:0] l1_exit_fts_count;
  wire [2:0] l1_base_latency, l0s_base_latency, l1_exit_latency_field, l0s_exit_latency;
  wire [1:0] active_state_pm_control;
  wire clock_request_pm_enable, extended_sync, common_refclk_config, l0s_entry_allowed;
  wire l1_entry_allowed, aspm_reserved_seen, l1_exit_extra_ts2;
  integer n_mismatch = 0, samples_checked = 0, cyc = 0, i;
  ulc_partner u_far (.*);
  ulc_link_control dut (.*);
  always #5 ref_clk = ~ref_clk;
  // Ceiling is about twice the expected run length
  always @(posedge ref_clk) if (++cyc == 3000) begin
    n_mismatch++;
    test_done;
  end
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function [2:0] lat(input [2:0] lb, input c, input k);
    reg [3:0] t;
    begin
      t = (c && lb != 3'h0) ? lb - 3'h1 : lb;
      if (k) t = (t > 4'h5) ? 4'h7 : t + 4'h2;
      lat = t[2:0];
    end
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    begin
      samples_checked++;
      if (g !== e) begin
        n_mismatch++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task acc(input w, input [7:0] ad, input [1:0] be, input [15:0] wd);
    begin
      @(negedge ref_clk);
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, ad, be, wd};
      @(negedge ref_clk);
      {cfg_wr, cfg_rd} = 2'h0;
    end
  endtask
  task test_done;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // **
  // Main sequence
  // **
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'h0;
    chk(cfg_rdata, 16'h0);
    chk(l1_exit_fts_count, 8'h20);
    for (i = 0; i < 300; i++) begin
      if (i == 150) begin
        reset = 1'h1;
        @(negedge ref_clk);
        reset = 1'h0;
        exp_q = 16'h0;
      end
      r = lfsr(r);
      d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0 : lfsr(r);
      if (d[1:0] == `ULC_ASPM_RSVD) d[0] = 1'h1;
      b = (i < 2) ? 2'h3 : (i == 150) ? 2'h0 : r[7:6];
      a = (i < 2 || r[8]) ? 8'ha0 : r[15:8];
      pick = r[5:0];
      acc(1'h1, a, b, d);
      m = `ULC_WRITABLE_MASK & {{8{b[1]}}, {8{b[0]}}};
      if (a == 8'ha0) exp_q = (exp_q & ~m) | (d & m);
      acc(1'h0, a, 2'h0, 16'h0);
      @(negedge ref_clk);
      chk(cfg_rdata, (a == 8'ha0) ? exp_q : 16'h0);
      chk({clock_request_pm_enable, extended_sync, common_refclk_config}, exp_q[8:6]);
      chk({l1_exit_fts_count, l1_exit_extra_ts2}, {exp_q[7] ? 8'hff : 8'h20, exp_q[7]});
      chk({active_state_pm_control, l0s_entry_allowed, l1_entry_allowed, aspm_reserved_seen},
          {exp_q[1:0], exp_q[0], &exp_q[1:0], exp_q[1:0] == 2'h2});
      chk(l1_exit_latency_field, lat(l1_base_latency, exp_q[6], exp_q[8]));
      chk(l0s_exit_latency, lat(l0s_base_latency, exp_q[6], 1'h0));
    end
    $display("random register test done");
    test_done;
  end
endmodule // tb

// file: tb/ulc_link_control_assertions.sv
// Checker on the link control register ports
`timescale 1ns/100ps
// **
// Checks
// **
module ulc_chk (
  input wire ref_clk,
  input wire reset,
  input wire cfg_wr,
  input wire [15:0] cfg_rdata,
  input wire clock_request_pm_enable,
  input wire common_refclk_config,
  input wire extended_sync,
  input wire [1:0] active_state_pm_control,
  input wire l0s_entry_allowed,
  input wire l1_entry_allowed,
  input wire aspm_reserved_seen,
  input wire [7:0] l1_exit_fts_count,
  input wire l1_exit_extra_ts2
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  fixed_zero_a: assert property ((cfg_rdata & 16'hfe3c) == 16'h0) else $error("fixed");
  l1_decode_a: assert property (l1_entry_allowed == &active_state_pm_control) else $error("l1");
  l0s_decode_a: assert property (l0s_entry_allowed == active_state_pm_control[0]) else $error("l0s");
  code_ten_a: assert property (aspm_reserved_seen == (active_state_pm_control == 2'h2)) else $error("ten");
  fts_count_a: assert property (l1_exit_fts_count == (extended_sync ? 8'hff : 8'h20)) else $error("fts");
  extra_ts2_a: assert property (l1_exit_extra_ts2 == extended_sync) else $error("ts2");
  reset_clear_a: assert property (disable iff (1'b0) reset |=> !extended_sync && cfg_rdata == 16'h0) else $error("rst");
  ctl_hold_a: assert property (!cfg_wr [*2] |=> $stable({clock_request_pm_enable, extended_sync,
    common_refclk_config, active_state_pm_control})) else $error("hold");
endmodule // ulc_chk
bind ulc_link_control ulc_chk u_chk (.*);

// file: tb/ulc_partner.sv
// Link partner model reporting base exit latency codes
`timescale 1ns/100ps
module ulc_partner (
  input wire ref_clk,
  input wire [5:0] pick,
  output reg [2:0] l1_base_latency = 3'h0,
  output reg [2:0] l0s_base_latency = 3'h0
);
  // Codes move only at the falling edge, away from the sampling edge
  always @(negedge ref_clk) begin
    {l1_base_latency, l0s_base_latency} <= pick;
  end
endmodule // ulc_partner
